// ---- design/hsrm_defines.vh ----
`ifndef HSRM_DEFINES_VH
`define HSRM_DEFINES_VH

// Register offsets (word index)
`define HSRM_OFF_OPERATION_SETUP 5'h00
`define HSRM_OFF_AXIS_CHANNEL_SETUP 5'h01
`define HSRM_OFF_SYSTEM_SETUP 5'h02
`define HSRM_OFF_INTERRUPT_PIN_SETUP 5'h03
`define HSRM_OFF_X_LIMIT_SETUP 5'h04
`define HSRM_OFF_Y_LIMIT_SETUP 5'h05
`define HSRM_OFF_Z_LIMIT_SETUP 5'h06
`define HSRM_OFF_TEMP_LIMIT_SETUP 5'h07
`define HSRM_OFF_CONVERSION_STATE 5'h08
`define HSRM_OFF_X_FIELD_VALUE 5'h09
`define HSRM_OFF_Y_FIELD_VALUE 5'h0A
`define HSRM_OFF_Z_FIELD_VALUE 5'h0B
`define HSRM_OFF_TEMP_VALUE 5'h0C
`define HSRM_OFF_FRONTEND_STATE 5'h0D
`define HSRM_OFF_SYSTEM_STATE 5'h0E
`define HSRM_OFF_TEST_SETUP 5'h0F
`define HSRM_OFF_CLOCK_MONITOR 5'h10
`define HSRM_OFF_GAIN_TRIM 5'h11
`define HSRM_OFF_OFFSET_TRIM 5'h12
`define HSRM_OFF_ANGLE_VALUE 5'h13
`define HSRM_OFF_FIELD_MAGNITUDE 5'h14
`define HSRM_OFF_LAST 5'h14

// Operation setup fields
`define HSRM_AVG_HI 14
`define HSRM_AVG_LO 12
`define HSRM_DRIFT_HI 9
`define HSRM_DRIFT_LO 8
`define HSRM_MODE_HI 6
`define HSRM_MODE_LO 4
`define HSRM_TEMP_ON_BIT 3
`define HSRM_TEMP_RATE_BIT 2
`define HSRM_TEMP_CHECK_BIT 1
`define HSRM_OPSETUP_RESET 16'h0000
`define HSRM_OPSETUP_MASK 16'h737E
`define HSRM_RW_RESET 16'h0000

// Averaging codes
`define HSRM_AVG_1X 3'h0
`define HSRM_AVG_32X 3'h5

// Operating modes
`define HSRM_MODE_CONFIG 3'h0
`define HSRM_MODE_STANDBY 3'h1
`define HSRM_MODE_ACTIVE 3'h2
`define HSRM_MODE_TRIGGER 3'h3
`define HSRM_MODE_DUTY 3'h4
`define HSRM_MODE_SLEEP 3'h5
`define HSRM_MODE_DEEP 3'h6
`define HSRM_MODE_UNUSED 3'h7

`endif

// ---- design/hsrm_register_bank.v ----
// Function
// RL1 - Controller must not write offsets missing from the map.
// RL2 - Offsets 0h to 14h form the map; all others are reserved.
// RL3 - Operation setup register resets to all zeros.
// RL4 - Bits 14-12 choose averaging 1x to 32x for codes 0h to 5h.
// RL5 - Averaging codes 6h and 7h are stored as 000b.
// RL6 - Bits 9-8 choose magnet temperature-drift compensation.
// RL7 - Bits 6-4 choose operating mode codes 0h to 6h.
// RL8 - Mode 2h converts continuously with no trigger.
// RL9 - Modes 0h, 1h and 3h start conversions from the trigger source.
// RL10 - Mode 4h alternates conversions with sleep intervals.
// RL11 - Mode 6h sleeps deeply until chip select asserts, then wakes.
// RL12 - Operating mode code 7h is stored as 000b.
// RL13 - Bit 3 enables temperature acquisition, off by default.
// RL14 - Bit 2 selects temperature rate: every sample or once per set.
// RL15 - Bit 1 enables temperature limit check, off by default.
// RL16 - Registers are 16 bits; a read returns within one SPI frame.
// RL17 - Reserved operation setup bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "hsrm_defines.vh"

module hsrm_register_bank
(
   input wire clk_sys,
   input wire rst,
   input wire wr_en,
   input wire rd_en,
   input wire [4:0] reg_addr,
   input wire [15:0] wr_data,
   input wire cs_asserted,
   input wire trigger_req,
   input wire sleep_done,
   input wire conv_done,
   input wire [15:0] conversion_state_in,
   input wire [15:0] x_field_in,
   input wire [15:0] y_field_in,
   input wire [15:0] z_field_in,
   input wire [15:0] temp_in,
   input wire [15:0] frontend_state_in,
   input wire [15:0] system_state_in,
   input wire [15:0] clock_monitor_in,
   input wire [15:0] angle_in,
   input wire [15:0] magnitude_in,
   output reg [15:0] rd_data,
   output reg rd_valid,
   output reg addr_reserved,
   output reg [2:0] averaging_factor,
   output reg [1:0] magnet_drift_comp,
   output reg [2:0] operating_mode,
   output reg temp_acquire_on,
   output reg temp_rate_once,
   output reg temp_limit_check_on,
   output reg conv_start,
   output reg asleep,
   output reg [15:0] axis_channel_setup,
   output reg [15:0] system_setup,
   output reg [15:0] interrupt_pin_setup,
   output reg [15:0] x_limit_setup,
   output reg [15:0] y_limit_setup,
   output reg [15:0] z_limit_setup,
   output reg [15:0] temp_limit_setup,
   output reg [15:0] test_setup,
   output reg [15:0] gain_trim,
   output reg [15:0] offset_trim
);

   // ==========================================================
   // Helpers
   // ==========================================================
   function hsrm_is_mapped;
      input [4:0] addr;
      begin
         hsrm_is_mapped = (addr <= `HSRM_OFF_LAST); // RL2
      end
   endfunction

   function [2:0] hsrm_fix_avg;
      input [2:0] code;
      begin
         if (code > `HSRM_AVG_32X)
         begin
            hsrm_fix_avg = `HSRM_AVG_1X; // RL5
         end
         else
         begin
            hsrm_fix_avg = code; // RL4
         end
      end
   endfunction

   function [2:0] hsrm_fix_mode;
      input [2:0] code;
      begin
         if (code == `HSRM_MODE_UNUSED)
         begin
            hsrm_fix_mode = `HSRM_MODE_CONFIG; // RL12
         end
         else
         begin
            hsrm_fix_mode = code; // RL7
         end
      end
   endfunction

   // ==========================================================
   // Write decode
   // ==========================================================
   wire wr_hit;
   wire [2:0] wr_mode;
   assign wr_hit = wr_en && hsrm_is_mapped(reg_addr); // RL2
   assign wr_mode = hsrm_fix_mode(wr_data[`HSRM_MODE_HI:`HSRM_MODE_LO]);

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         averaging_factor <= 3'h0; // RL3
         magnet_drift_comp <= 2'h0;
         operating_mode <= `HSRM_MODE_CONFIG;
         temp_acquire_on <= 1'b0;
         temp_rate_once <= 1'b0;
         temp_limit_check_on <= 1'b0;
         axis_channel_setup <= `HSRM_RW_RESET;
         system_setup <= `HSRM_RW_RESET;
         interrupt_pin_setup <= `HSRM_RW_RESET;
         x_limit_setup <= `HSRM_RW_RESET;
         y_limit_setup <= `HSRM_RW_RESET;
         z_limit_setup <= `HSRM_RW_RESET;
         temp_limit_setup <= `HSRM_RW_RESET;
         test_setup <= `HSRM_RW_RESET;
         gain_trim <= `HSRM_RW_RESET;
         offset_trim <= `HSRM_RW_RESET;
      end
      else if (wr_hit)
      begin
         if (reg_addr == `HSRM_OFF_OPERATION_SETUP)
         begin
            // Reserved bits are simply not stored
            averaging_factor <=
               hsrm_fix_avg(wr_data[`HSRM_AVG_HI:`HSRM_AVG_LO]); // RL5
            magnet_drift_comp <=
               wr_data[`HSRM_DRIFT_HI:`HSRM_DRIFT_LO]; // RL6
            operating_mode <= wr_mode; // RL12
            temp_acquire_on <= wr_data[`HSRM_TEMP_ON_BIT]; // RL13
            temp_rate_once <= wr_data[`HSRM_TEMP_RATE_BIT]; // RL14
            temp_limit_check_on <= wr_data[`HSRM_TEMP_CHECK_BIT]; // RL15
         end
         else if (reg_addr == `HSRM_OFF_AXIS_CHANNEL_SETUP)
         begin
            axis_channel_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_SYSTEM_SETUP)
         begin
            system_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_INTERRUPT_PIN_SETUP)
         begin
            interrupt_pin_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_X_LIMIT_SETUP)
         begin
            x_limit_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_Y_LIMIT_SETUP)
         begin
            y_limit_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_Z_LIMIT_SETUP)
         begin
            z_limit_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_TEMP_LIMIT_SETUP)
         begin
            temp_limit_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_TEST_SETUP)
         begin
            test_setup <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_GAIN_TRIM)
         begin
            gain_trim <= wr_data;
         end
         else if (reg_addr == `HSRM_OFF_OFFSET_TRIM)
         begin
            offset_trim <= wr_data;
         end
      end
   end

   // ==========================================================
   // Read decode
   // ==========================================================
   reg [15:0] next_rd_data;
   always @*
   begin
      next_rd_data = 16'h0000;
      if (reg_addr == `HSRM_OFF_OPERATION_SETUP)
      begin
         next_rd_data = {1'b0, averaging_factor, 2'b00, magnet_drift_comp,
            1'b0, operating_mode, temp_acquire_on, temp_rate_once,
            temp_limit_check_on, 1'b0}; // RL17
      end
      else if (reg_addr == `HSRM_OFF_AXIS_CHANNEL_SETUP)
         next_rd_data = axis_channel_setup;
      else if (reg_addr == `HSRM_OFF_SYSTEM_SETUP)
         next_rd_data = system_setup;
      else if (reg_addr == `HSRM_OFF_INTERRUPT_PIN_SETUP)
         next_rd_data = interrupt_pin_setup;
      else if (reg_addr == `HSRM_OFF_X_LIMIT_SETUP)
         next_rd_data = x_limit_setup;
      else if (reg_addr == `HSRM_OFF_Y_LIMIT_SETUP)
         next_rd_data = y_limit_setup;
      else if (reg_addr == `HSRM_OFF_Z_LIMIT_SETUP)
         next_rd_data = z_limit_setup;
      else if (reg_addr == `HSRM_OFF_TEMP_LIMIT_SETUP)
         next_rd_data = temp_limit_setup;
      else if (reg_addr == `HSRM_OFF_CONVERSION_STATE)
         next_rd_data = conversion_state_in;
      else if (reg_addr == `HSRM_OFF_X_FIELD_VALUE)
         next_rd_data = x_field_in;
      else if (reg_addr == `HSRM_OFF_Y_FIELD_VALUE)
         next_rd_data = y_field_in;
      else if (reg_addr == `HSRM_OFF_Z_FIELD_VALUE)
         next_rd_data = z_field_in;
      else if (reg_addr == `HSRM_OFF_TEMP_VALUE)
         next_rd_data = temp_in;
      else if (reg_addr == `HSRM_OFF_FRONTEND_STATE)
         next_rd_data = frontend_state_in;
      else if (reg_addr == `HSRM_OFF_SYSTEM_STATE)
         next_rd_data = system_state_in;
      else if (reg_addr == `HSRM_OFF_TEST_SETUP)
         next_rd_data = test_setup;
      else if (reg_addr == `HSRM_OFF_CLOCK_MONITOR)
         next_rd_data = clock_monitor_in;
      else if (reg_addr == `HSRM_OFF_GAIN_TRIM)
         next_rd_data = gain_trim;
      else if (reg_addr == `HSRM_OFF_OFFSET_TRIM)
         next_rd_data = offset_trim;
      else if (reg_addr == `HSRM_OFF_ANGLE_VALUE)
         next_rd_data = angle_in;
      else if (reg_addr == `HSRM_OFF_FIELD_MAGNITUDE)
         next_rd_data = magnitude_in;
   end

   // Read answer one cycle after the strobe, well inside a frame
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
         addr_reserved <= 1'b0;
      end
      else
      begin
         rd_valid <= rd_en; // RL16
         addr_reserved <= (rd_en || wr_en) && !hsrm_is_mapped(reg_addr); // RL2
         if (rd_en)
         begin
            rd_data <= next_rd_data; // RL16
         end
      end
   end

   // ==========================================================
   // Conversion sequencing by mode
   // ==========================================================
   reg duty_phase_sleep;
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         conv_start <= 1'b0;
         asleep <= 1'b0;
         duty_phase_sleep <= 1'b0;
      end
      else
      begin
         conv_start <= 1'b0;
         asleep <= 1'b0;
         if (operating_mode == `HSRM_MODE_ACTIVE)
         begin
            conv_start <= 1'b1; // RL8
            duty_phase_sleep <= 1'b0;
         end
         else if ((operating_mode == `HSRM_MODE_CONFIG) ||
            (operating_mode == `HSRM_MODE_STANDBY) ||
            (operating_mode == `HSRM_MODE_TRIGGER))
         begin
            conv_start <= trigger_req; // RL9
            duty_phase_sleep <= 1'b0;
         end
         else if (operating_mode == `HSRM_MODE_DUTY)
         begin
            if (duty_phase_sleep)
            begin
               asleep <= !sleep_done; // RL10
               if (sleep_done)
               begin
                  duty_phase_sleep <= 1'b0;
                  conv_start <= 1'b1; // RL10
               end
            end
            else if (conv_done)
            begin
               duty_phase_sleep <= 1'b1; // RL10
               asleep <= 1'b1;
            end
         end
         else if (operating_mode == `HSRM_MODE_DEEP)
         begin
            asleep <= !cs_asserted; // RL11
            duty_phase_sleep <= 1'b0;
         end
         else
         begin
            asleep <= 1'b1;
            duty_phase_sleep <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ---- sim/hsrm_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hsrm_ctrl_model (
   input wire logic clk_sys,
   output logic wr_en,
   output logic rd_en,
   output logic [4:0] reg_addr,
   output logic [15:0] wr_data
);
   // ======================================
   // One-word access, taken on one edge
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      reg_addr = 5'h00;
      wr_data = 16'h0000;
   end
   task automatic put(input logic [4:0] a, input logic [15:0] d,
                      input logic r);
      @(negedge clk_sys);
      reg_addr = a;
      wr_data = d;
      rd_en = r;
      wr_en = !r;
      @(negedge clk_sys);
      rd_en = 1'b0;
      wr_en = 1'b0;
      // Released lines show inverted content
      reg_addr = ~a;
      wr_data = ~d;
   endtask
endmodule
`default_nettype wire

// ---- sim/hsrm_register_bank_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module hsrm_bank_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic cs_asserted,
   input wire logic trigger_req,
   input wire logic conv_done,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic addr_reserved,
   input wire logic [2:0] averaging_factor,
   input wire logic [2:0] operating_mode,
   input wire logic conv_start,
   input wire logic asleep
);
   // ======================================
   // Port relations
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence duty_sleep_s;
      ##1 asleep;
   endsequence
   rd_answer_a: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   rsv_flag_a: assert property
      ((rd_en || wr_en) && reg_addr > 5'h14 |=> addr_reserved)
      else $error("reserved offset not flagged");
   rsv_zero_a: assert property
      (rd_en && reg_addr > 5'h14 |=> rd_data == 16'h0000)
      else $error("reserved offset read not zero");
   rsv_bits_a: assert property
      (rd_en && reg_addr == 5'h00 |=> (rd_data & 16'h8C81) == 16'h0000)
      else $error("reserved setup bits not zero");
   avg_code_a: assert property (averaging_factor <= 3'h5)
      else $error("unused averaging code held");
   mode_code_a: assert property (operating_mode != 3'h7)
      else $error("unused mode code held");
   active_run_a: assert property
      (operating_mode == 3'h2 && $past(operating_mode) == 3'h2 |-> conv_start)
      else $error("active mode not converting");
   trig_follow_a: assert property
      (operating_mode inside {3'h0, 3'h1, 3'h3} && $stable(operating_mode)
       |-> conv_start == $past(trigger_req))
      else $error("start does not follow trigger");
   deep_wake_a: assert property
      (operating_mode == 3'h6 && $past(operating_mode) == 3'h6
       |-> asleep == !$past(cs_asserted))
      else $error("deep sleep not tied to select");
   duty_sleep_a: assert property
      (operating_mode == 3'h4 && !asleep && conv_done |-> duty_sleep_s)
      else $error("no sleep after conversion");
endmodule
bind hsrm_register_bank hsrm_bank_chk chk (.clk_sys(clk_sys), .rst(rst),
   .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
   .cs_asserted(cs_asserted), .trigger_req(trigger_req),
   .conv_done(conv_done), .rd_data(rd_data), .rd_valid(rd_valid),
   .addr_reserved(addr_reserved), .averaging_factor(averaging_factor),
   .operating_mode(operating_mode), .conv_start(conv_start),
   .asleep(asleep));
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic cs_asserted = 1'b0;
   logic trigger_req = 1'b0;
   logic sleep_done = 1'b0;
   logic conv_done = 1'b0;
   logic [15:0] ro_val [8:20];
   logic wr_en, rd_en, rd_valid, addr_reserved, conv_start, asleep;
   logic [4:0] reg_addr;
   logic [15:0] wr_data, rd_data, got;
   logic [2:0] av, md, averaging_factor, operating_mode;
   logic [4:0] rw_off [10] = '{1, 2, 3, 4, 5, 6, 7, 15, 17, 18};
   wire logic [15:0] rw_out [0:9];
   wire logic [1:0] dc;
   wire logic ta, tr, tc;
   int errors = 0;
   int cmp_count = 0;
   int i;
   always #25 clk_sys = ~clk_sys;
   hsrm_ctrl_model ctrl (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en),
      .reg_addr(reg_addr), .wr_data(wr_data));
   hsrm_register_bank dut (.clk_sys(clk_sys), .rst(rst), .wr_en(wr_en),
      .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data),
      .cs_asserted(cs_asserted), .trigger_req(trigger_req),
      .sleep_done(sleep_done), .conv_done(conv_done),
      .conversion_state_in(ro_val[8]), .x_field_in(ro_val[9]),
      .y_field_in(ro_val[10]), .z_field_in(ro_val[11]),
      .temp_in(ro_val[12]), .frontend_state_in(ro_val[13]),
      .system_state_in(ro_val[14]), .clock_monitor_in(ro_val[16]),
      .angle_in(ro_val[19]), .magnitude_in(ro_val[20]),
      .rd_data(rd_data), .rd_valid(rd_valid), .addr_reserved(addr_reserved),
      .averaging_factor(averaging_factor), .magnet_drift_comp(dc),
      .operating_mode(operating_mode), .temp_acquire_on(ta),
      .temp_rate_once(tr), .temp_limit_check_on(tc), .conv_start(conv_start),
      .asleep(asleep), .axis_channel_setup(rw_out[0]),
      .system_setup(rw_out[1]), .interrupt_pin_setup(rw_out[2]),
      .x_limit_setup(rw_out[3]), .y_limit_setup(rw_out[4]),
      .z_limit_setup(rw_out[5]), .temp_limit_setup(rw_out[6]),
      .test_setup(rw_out[7]), .gain_trim(rw_out[8]),
      .offset_trim(rw_out[9]));
   // ======================================
   // Tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                      input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      ctrl.put(a, d, 1'b0);
   endtask
   task automatic rd(input logic [4:0] a);
      ctrl.put(a, 16'h0000, 1'b1);
      chk({15'h0000, rd_valid}, 16'h0001, "rd_valid");
      got = rd_data;
   endtask
   task automatic bit1(input logic seen, input logic exp, input string w);
      chk({15'h0000, seen}, {15'h0000, exp}, w);
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      errors++;
      final_report;
   end
   // ======================================
   // Tests
   initial
   begin
      for (i = 8; i <= 20; i++)
         ro_val[i] = {8'hC5, i[7:0]};
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      rd(5'h00);
      chk(got, 16'h0000, "op setup reset");
      $display("test reset done");
      for (i = 0; i < 10; i++)
      begin
         rd(rw_off[i]);
         chk(got, 16'h0000, "rw reset");
         wr(rw_off[i], {8'hA5, 3'h0, rw_off[i]});
         chk(rw_out[i], {8'hA5, 3'h0, rw_off[i]}, "rw port");
         rd(rw_off[i]);
         chk(got, {8'hA5, 3'h0, rw_off[i]}, "rw data");
      end
      for (i = 8; i <= 20; i++)
         if (i < 15 || i == 16 || i > 18)
         begin
            wr(i[4:0], 16'hFFFF);
            rd(i[4:0]);
            chk(got, ro_val[i], "ro data");
         end
      // Unmapped offsets are only read, never written
      for (i = 21; i < 32; i += 10)
      begin
         rd(i[4:0]);
         chk(got, 16'h0000, "rsv data");
         bit1(addr_reserved, 1'b1, "rsv flag");
      end
      $display("test map done");
      for (i = 0; i < 8; i++)
      begin
         av = (i > 5) ? 3'h0 : i[2:0];
         md = (i == 7) ? 3'h0 : i[2:0];
         wr(5'h00, {1'b1, i[2:0], 2'b11, i[1:0], 1'b1, i[2:0], i[2:0], 1'b1});
         rd(5'h00);
         chk(got, {1'b0, av, 2'b00, i[1:0], 1'b0, md, i[2:0], 1'b0},
             "op setup");
         chk({13'h0000, operating_mode}, {13'h0000, md}, "mode");
         chk({13'h0000, averaging_factor}, {13'h0000, av}, "avg");
         chk({11'h000, dc, ta, tr, tc}, {11'h000, i[1:0], i[2:0]},
             "fields");
      end
      $display("test fields done");
      wr(5'h00, 16'h0020);
      repeat (2) @(negedge clk_sys);
      bit1(conv_start, 1'b1, "active start");
      wr(5'h00, 16'h0030);
      trigger_req = 1'b1;
      @(negedge clk_sys);
      bit1(conv_start, 1'b1, "trigger start");
      trigger_req = 1'b0;
      @(negedge clk_sys);
      bit1(conv_start, 1'b0, "trigger idle");
      wr(5'h00, 16'h0060);
      @(negedge clk_sys);
      bit1(asleep, 1'b1, "deep sleep");
      cs_asserted = 1'b1;
      @(negedge clk_sys);
      bit1(asleep, 1'b0, "deep wake");
      cs_asserted = 1'b0;
      wr(5'h00, 16'h0040);
      @(negedge clk_sys);
      bit1(asleep, 1'b0, "duty awake");
      conv_done = 1'b1;
      @(negedge clk_sys);
      conv_done = 1'b0;
      bit1(asleep, 1'b1, "duty sleep");
      sleep_done = 1'b1;
      @(negedge clk_sys);
      sleep_done = 1'b0;
      bit1(conv_start, 1'b1, "duty start");
      wr(5'h00, 16'h0050);
      @(negedge clk_sys);
      bit1(asleep, 1'b1, "sleep mode");
      $display("test modes done");
      final_report;
   end
endmodule
`default_nettype wire
